// file: design/pss_shift.sv
// pss_shift.sv: eight-stage parallel/serial shift register, top module
// assumes: control and data pins arrive asynchronously to core_clk;
// the shift clock pin is sampled and its rising edge detected
// limitation: clear and load act on the synchronised level, a few core
// clocks after the pin moves, not truly asynchronously
`timescale 1ns/1ps
`include "pss_map.svh"

// Contract
// - direction low: parallel pins driven with the stage contents
// - direction high: parallel pins are inputs, not driven
// - shift clock rise with clear/load high: serial input into stage one
// - same edge: stages two to eight take the previous stage
// - direction low, clear/load low: all stages cleared, clock ignored
// - direction high, clear/load low: stages copy the parallel pins
// - clear/load high, no shift edge: stages hold
// - registered serial output shows stage eight, holds when not updated
// - pin drivers enabled from direction select only
module pss_shift
	import pss_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             direction_select,
	input  wire logic             clear_or_load_n,
	input  wire logic             shift_clock,
	input  wire logic             serial_in,
	input  wire logic [7:0]       parallel_pins_in,
	output logic      [7:0]       parallel_pins_out,
	output logic      [7:0]       parallel_pins_oe,
	output logic                  serial_out_registered,
	output logic                  serial_out_direct
);
	// ----------------------------------------------------------------
	// reset release and input synchronisation
	// ----------------------------------------------------------------
	logic        rst1_reg;
	logic        rst2_reg;
	logic [11:0] pins_sync;
	logic        dir_s;
	logic        clr_n_s;
	logic        sck_s;
	logic        sin_s;
	logic [7:0]  pin_s;
	logic        sck_prev_reg;
	pss_stage_t  stage_reg;
	pss_stage_t  stage_next;
	pss_stage_t  force_value;
	pss_op_e     op;
	wire logic   sck_rise;

	// reset copy released through two flops
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst1_reg <= 1'b0;
			rst2_reg <= 1'b0;
		end
		else
		begin
			rst1_reg <= 1'b1;
			rst2_reg <= rst1_reg;
		end
	end

	// every control and data pin passes the three-flop filter; the shift clock
	// edge is detected only on the filtered level, so glitches cannot shift
	pss_sync #(
		.W (12)
	) u_sync (
		.clk      (core_clk),
		.rst_n    (rst2_reg),
		.async_in ({direction_select, clear_or_load_n, shift_clock, serial_in,
		            parallel_pins_in}),
		.sync_out (pins_sync)
	);

	assign {dir_s, clr_n_s, sck_s, sin_s, pin_s} = pins_sync;

	// ----------------------------------------------------------------
	// operation decode
	// ----------------------------------------------------------------
	function automatic pss_op_e pss_decode(input logic clr_n, input logic rise);
		pss_op_e r;
		r = PSS_OP_HOLD;
		if (!clr_n)
			r = PSS_OP_FORCE;
		else if (rise)
			r = PSS_OP_SHIFT;
		return r;
	endfunction

	assign sck_rise = sck_s & ~sck_prev_reg;
	assign op       = pss_decode(clr_n_s, sck_rise);

	// value forced while clear/load is low: the pins in input mode, zero otherwise
	assign force_value = dir_s ? pin_s : `PSS_STAGE_RESET;

	// next stage contents; stage_reg[0] is stage one
	always_comb
	begin
		case (op)
			PSS_OP_FORCE: stage_next = force_value;
			PSS_OP_SHIFT: stage_next = {stage_reg[6:0], sin_s};
			PSS_OP_HOLD:  stage_next = stage_reg;
			default:      stage_next = stage_reg;
		endcase
	end

	// ----------------------------------------------------------------
	// stage register and outputs
	// ----------------------------------------------------------------
	// previous filtered shift clock level, for rising edge detection
	always_ff @(posedge core_clk or negedge rst2_reg)
	begin
		if (!rst2_reg)
			sck_prev_reg <= 1'b0;
		else
			sck_prev_reg <= sck_s;
	end

	// stages and their copies on the pins
	always_ff @(posedge core_clk or negedge rst2_reg)
	begin
		if (!rst2_reg)
		begin
			stage_reg             <= `PSS_STAGE_RESET;
			parallel_pins_out     <= `PSS_STAGE_RESET;
			parallel_pins_oe      <= 8'h00;
			serial_out_registered <= 1'b0;
			serial_out_direct     <= 1'b0;
		end
		else
		begin
			stage_reg             <= stage_next;
			parallel_pins_out     <= stage_next;
			parallel_pins_oe      <= {8{~dir_s}};
			serial_out_registered <= stage_next[`PSS_STAGES-1];
			serial_out_direct     <= stage_next[`PSS_STAGES-1];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_rise_no_force;
		clr_n_s && sck_rise;
	endsequence

	a_shift_first: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		s_rise_no_force |=> stage_reg[0] == $past(sin_s))
		else $error("stage one missed serial input");

	a_shift_chain: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		s_rise_no_force |=> stage_reg[7:1] == $past(stage_reg[6:0]))
		else $error("stages did not shift");

	a_clear_out: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		(!clr_n_s && !dir_s) |=> stage_reg == 8'h00)
		else $error("clear failed");

	a_load_pins: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		(!clr_n_s && dir_s) |=> stage_reg == $past(pin_s))
		else $error("parallel load failed");

	a_hold_stages: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		(clr_n_s && !sck_rise) |=> $stable(stage_reg))
		else $error("stages changed without edge");

	a_pins_track: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		parallel_pins_oe == 8'hff |-> parallel_pins_out == stage_reg)
		else $error("pins differ from stages");

	a_oe_dir: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		dir_s |=> parallel_pins_oe == 8'h00)
		else $error("pins driven in input mode");

	a_oe_only_dir: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		!dir_s |=> parallel_pins_oe == 8'hff)
		else $error("pins not driven in output mode");

	a_serial_last: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		##1 serial_out_registered == stage_reg[7])
		else $error("serial output differs from stage eight");

	// direction pin held at its new level long enough to reach the enables
	sequence s_dir_to_out;
		$fell(direction_select) ##1 (!direction_select) [*6];
	endsequence

	sequence s_dir_to_in;
		$rose(direction_select) ##1 (direction_select) [*6];
	endsequence

	// clear/load released with no shift edge in the release cycle
	sequence s_force_released;
		!clr_n_s ##1 (clr_n_s && !sck_rise);
	endsequence

	a_oe_to_out: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		s_dir_to_out |-> parallel_pins_oe == 8'hff)
		else $error("enables did not follow direction low");

	a_oe_to_in: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		s_dir_to_in |-> parallel_pins_oe == 8'h00)
		else $error("enables did not follow direction high");

	a_release_holds: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		s_force_released |=> $stable(stage_reg))
		else $error("stages moved after clear/load release");

	a_serial_hold: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		$stable(stage_reg) |-> $stable(serial_out_registered))
		else $error("serial output moved while stages held");

	a_direct_copy: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		serial_out_direct == serial_out_registered)
		else $error("direct serial output differs");

	a_oe_whole: assert property (@(posedge core_clk) disable iff (!rst2_reg)
		parallel_pins_oe == 8'h00 || parallel_pins_oe == 8'hff)
		else $error("pin enables split");
endmodule

// file: design/pss_map.svh
// pss_map.svh: constants of the parallel/serial shift register
// assumes: included by the package and the top module
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_STAGES      8
`define PSS_STAGE_RESET 8'h00
`define PSS_SYNC_DEPTH  3
`endif

// file: design/pss_pkg.sv
// pss_pkg.sv: types of the parallel/serial shift register
// assumes: pss_map.svh on the include path
`include "pss_map.svh"
package pss_pkg;
	typedef logic [`PSS_STAGES-1:0] pss_stage_t;
	// operation taken at one core clock edge
	typedef enum logic [2:0]
	{
		PSS_OP_HOLD  = 3'b001,
		PSS_OP_SHIFT = 3'b010,
		PSS_OP_FORCE = 3'b100
	} pss_op_e;
endpackage

// file: design/pss_sync.sv
// pss_sync.sv: three-flop input synchroniser with agreement filter
// assumes: one clock domain, active-low async reset
`timescale 1ns/1ps
module pss_sync
	import pss_pkg::*;
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] sync_next;

	// each bit changes only when its stages two and three agree, so a pin that
	// keeps moving cannot hold back the other bits
	assign sync_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & sync_out);

	// ----------------------------------------------------------------
	// synchroniser chain
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1_reg   <= async_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			sync_out <= sync_next;
		end
	end
endmodule

// file: sim/pss_host.sv
// pss_host.sv: host model that drives the control, serial and parallel pins
// assumes: one core_clk; the bench calls its tasks
`timescale 1ns/1ps
module pss_host
(
	input  wire logic [7:0] pins_out,
	input  wire logic [7:0] pins_oe,
	input  wire logic       core_clk,
	output logic            direction_select,
	output logic            clear_or_load_n,
	output logic            shift_clock,
	output logic            serial_in,
	output logic [7:0]      pins_in
);
	logic [7:0] host_data;
	logic [7:0] float_reg = 8'h5a;
	// a pin that nobody drives wanders every cycle
	always @(posedge core_clk)
		float_reg <= ~float_reg;
	// wire level from both parties' enables; host drives only in input mode
	assign pins_in = (pins_oe & pins_out) | (~pins_oe & (direction_select ? host_data : float_reg));
	initial
	begin
		{direction_select, shift_clock, serial_in, host_data} = 11'h000;
		clear_or_load_n = 1'b1;
	end
	// wait n edges, then step just past the edge
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// clear or load with a shift clock pulse inside it; released before the next rise
	task automatic force_op(input logic dir, input logic [7:0] data);
		direction_select = dir;
		host_data = data;
		clear_or_load_n = 1'b0;
		idle(5);
		shift_clock = 1'b1;
		idle(8);
		shift_clock = 1'b0;
		idle(8);
		clear_or_load_n = 1'b1;
		idle(10);
	endtask
	// one shift clock period, data steady well before the rise
	task automatic shift(input logic b);
		serial_in = b;
		idle(8);
		shift_clock = 1'b1;
		idle(8);
		shift_clock = 1'b0;
		idle(8);
	endtask
	// change direction only, then let it reach the pin enables
	task automatic set_dir(input logic dir);
		direction_select = dir;
		idle(10);
	endtask
endmodule

// file: sim/tb_top.sv
// tb_top.sv: self-checking bench of the parallel/serial shift register
// assumes: pss_pkg compiled first, pss_host as the pin partner
`timescale 1ns/1ps
module tb_top
	import pss_pkg::*;
;
	logic        core_clk, rst_n, probe, b;
	logic        direction_select, clear_or_load_n, shift_clock, serial_in;
	logic [7:0]  parallel_pins_in, parallel_pins_out, parallel_pins_oe;
	logic        serial_out_registered, serial_out_direct;
	int          failures, check_count, cycles;
	integer      seed;
	logic [17:0] exp_q[$];
	pss_stage_t  model;
	pss_shift u_pss_shift (.core_clk(core_clk), .rst_n(rst_n),
		.direction_select(direction_select), .clear_or_load_n(clear_or_load_n),
		.shift_clock(shift_clock), .serial_in(serial_in),
		.parallel_pins_in(parallel_pins_in), .parallel_pins_out(parallel_pins_out),
		.parallel_pins_oe(parallel_pins_oe), .serial_out_registered(serial_out_registered),
		.serial_out_direct(serial_out_direct));
	pss_host u_pss_host (.pins_out(parallel_pins_out), .pins_oe(parallel_pins_oe),
		.core_clk(core_clk), .direction_select(direction_select),
		.clear_or_load_n(clear_or_load_n), .shift_clock(shift_clock),
		.serial_in(serial_in), .pins_in(parallel_pins_in));
	// 200 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [17:0] seen, input logic [17:0] want);
		check_count++;
		if (seen !== want)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	// note the expected pins, enables and serial outputs, then ask for a look
	task automatic expect_now(input logic dir);
		exp_q.push_back({model, dir ? 8'h00 : 8'hff, model[7], model[7]});
		@(posedge core_clk) #1 probe = 1'b1;
		@(posedge core_clk) #1 probe = 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// monitor: oldest note against the outputs
	always @(posedge core_clk)
		if (probe)
			check({parallel_pins_out, parallel_pins_oe, serial_out_registered,
				serial_out_direct}, exp_q.pop_front());
	// hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			tally_and_finish();
		end
	end
	initial
	begin
		{rst_n, probe, model} = 10'h000;
		seed = 32'h333c7e10;
		repeat (10) @(posedge core_clk);
		#1 rst_n = 1'b1;
		u_pss_host.idle(10);
		expect_now(1'b0);
		for (int i = 0; i < 8; i++)
		begin
			b = (i == 0) ? 1'b1 : 1'($random(seed));
			u_pss_host.shift(b);
			model = {model[6:0], b};
			expect_now(1'b0);
		end
		u_pss_host.idle(40);
		expect_now(1'b0);
		$display("serial-in parallel-out test done");
		u_pss_host.force_op(1'b0, 8'hff);
		model = 8'h00;
		expect_now(1'b0);
		$display("clear test done");
		model = 8'($random(seed));
		u_pss_host.force_op(1'b1, model);
		expect_now(1'b1);
		for (int i = 0; i < 3; i++)
		begin
			b = 1'($random(seed));
			u_pss_host.shift(b);
			model = {model[6:0], b};
			expect_now(1'b1);
		end
		$display("parallel-in serial-out test done");
		u_pss_host.set_dir(1'b0);
		expect_now(1'b0);
		$display("return to output mode test done");
		tally_and_finish();
	end
endmodule
